// *** hw/periodic_timer.sv ***
/*
 Periodic 10-bit timer with comparators A and P, four modes, one output pin.
 Assumes a classic Wishbone master on the same clock; the external count
 pin and the slow clock enables arrive asynchronously and are synchronised.
*/
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "periodic_timer_defines.svh"

module periodic_timer
	import periodic_timer_pkg::*;
(
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	// Register bus
	input  wire periodic_timer_pkg::wb_req_t wbReq,
	output periodic_timer_pkg::wb_rsp_t      wbRsp,
	// Count clock sources
	input  wire logic                        extCountPin,
	input  wire logic                        fastClkTick,
	input  wire logic                        subClkTick,
	// Output pin
	output logic                             timerOut,
	output logic                             timerOutEn_n,
	// Match events
	output logic                             matchAPulse,
	output logic                             matchPPulse
);
	import periodic_timer_pkg::*;

	logic [7:0]  ctrl0_q;
	ctrl1_t      ctrl1_q;
	logic [9:0]  cmpA_q;
	logic [9:0]  period_q;
	logic [9:0]  count_q;
	logic        flagA_q;
	logic        flagP_q;
	logic        pin_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        runPrev_q;
	logic [1:0]  extSync_q;
	logic [1:0]  fastSync_q;
	logic [1:0]  subSync_q;
	logic        extLast_q;
	logic        fastLast_q;
	logic        subLast_q;
	logic [1:0]  div4_q;
	logic [3:0]  div16_q;
	logic [5:0]  div64_q;

	logic        runBit;
	logic        pauseBit;
	logic        runRise;
	logic        tick;
	logic        extEdge;
	logic        fastEdge;
	logic        subEdge;
	logic        pwmMode;
	logic        pulseMode;
	logic        matchA;
	logic        matchP;
	logic        clearCnt;
	logic        raiseA;
	logic        raiseP;
	logic        busWrite;
	logic        busRead;
	logic [9:0]  nextCount;
	logic        pwmActive;

	assign runBit    = ctrl0_q[`PT_CTRL0_RUN];
	assign pauseBit  = ctrl0_q[`PT_CTRL0_PAUSE];
	assign runRise   = runBit & ~runPrev_q;
	assign pwmMode   = (ctrl1_q.mode == MODE_PWM) & (ctrl1_q.pinAction != 2'h3);
	assign pulseMode = (ctrl1_q.mode == MODE_PWM) & (ctrl1_q.pinAction == 2'h3);
	assign busWrite  = wbReq.cyc & wbReq.stb & wbReq.we & ~ack_q & wbReq.sel[0];
	assign busRead   = wbReq.cyc & wbReq.stb & ~wbReq.we & ~ack_q;

	// Input synchronisers; first stage feeds only the second
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			extSync_q  <= 2'h0;
			fastSync_q <= 2'h0;
			subSync_q  <= 2'h0;
			extLast_q  <= 1'b0;
			fastLast_q <= 1'b0;
			subLast_q  <= 1'b0;
		end
		else
		begin
			extSync_q  <= {extSync_q[0], extCountPin};
			fastSync_q <= {fastSync_q[0], fastClkTick};
			subSync_q  <= {subSync_q[0], subClkTick};
			extLast_q  <= extSync_q[1];
			fastLast_q <= fastSync_q[1];
			subLast_q  <= subSync_q[1];
		end
	end

	// Pin edge polarity follows the clock select; rising when an internal source is chosen
	assign extEdge  = (ctrl0_q[`PT_CTRL0_CKHI:`PT_CTRL0_CKLO] == CLK_PIN_FALL) ?
	                  (extLast_q & ~extSync_q[1]) : (~extLast_q & extSync_q[1]);
	assign fastEdge = fastSync_q[1] & ~fastLast_q;
	assign subEdge  = subSync_q[1] & ~subLast_q;

	// Prescalers for the system and fast clock sources
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div4_q  <= 2'h0;
			div16_q <= 4'h0;
			div64_q <= 6'h0;
		end
		else
		begin
			div4_q <= div4_q + 2'h1;
			if (fastEdge)
			begin
				div16_q <= div16_q + 4'h1;
				div64_q <= div64_q + 6'h1;
			end
		end
	end

	// Count clock select
	always_comb
	begin
		case (clk_sel_t'(ctrl0_q[`PT_CTRL0_CKHI:`PT_CTRL0_CKLO]))
			CLK_SYS_DIV4: tick = (div4_q == `PT_DIV4);
			CLK_SYS:      tick = 1'b1;
			CLK_H_DIV16:  tick = fastEdge & (div16_q == `PT_DIV16);
			CLK_H_DIV64:  tick = fastEdge & (div64_q == `PT_DIV64);
			CLK_SUB_A:    tick = subEdge;
			CLK_SUB_B:    tick = subEdge;
			CLK_PIN_RISE: tick = extEdge;
			CLK_PIN_FALL: tick = extEdge;
			default:      tick = 1'b0;
		endcase
	end

	// Full-width compares; counting gated by run, pause and tick
	// A run start zeroes the count, so a residual count must not match in that cycle
	assign nextCount = count_q + 10'h1;
	assign matchA    = runBit & ~runRise & ~pauseBit & tick & (nextCount == cmpA_q)
	                   & (cmpA_q != 10'h0);
	assign matchP    = runBit & ~runRise & ~pauseBit & tick & (nextCount == period_q)
	                   & (period_q != 10'h0);

	// Flag and clear generation per mode
	always_comb
	begin
		raiseA   = 1'b0;
		raiseP   = 1'b0;
		clearCnt = 1'b0;
		if (pulseMode)
		begin
			// No clear and no period match in single pulse
			raiseA = matchA;
		end
		else if (pwmMode)
		begin
			raiseA   = matchA;
			raiseP   = matchP;
			clearCnt = matchP;
		end
		else if (ctrl1_q.clearSel)
		begin
			// Match A clears, no match P flag
			raiseA   = matchA;
			clearCnt = matchA;
		end
		else
		begin
			raiseA   = matchA;
			raiseP   = matchP;
			clearCnt = matchP;
		end
	end

	// Counter: zero on run rise, hold while off or paused
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			count_q <= 10'h0;
		else if (runRise)
			count_q <= 10'h0;
		else if (runBit & ~pauseBit & tick)
		begin
			// Wrap at 3FF gives 1024-count period when period is zero
			if (clearCnt)
				count_q <= 10'h0;
			else
				count_q <= nextCount;
		end
	end

	// Run edge history
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			runPrev_q <= 1'b0;
		else
			runPrev_q <= runBit;
	end

	// Control register 0; hardware set and clear of run win over software
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			ctrl0_q <= `PT_RESET_BYTE;
		else
		begin
			if (busWrite & (wbReq.adr == `PT_OFF_CTRL0))
				ctrl0_q <= {wbReq.dat[7:3], 3'h0};
			// Match A ends the pulse by dropping run
			if (pulseMode & raiseA)
				ctrl0_q[`PT_CTRL0_RUN] <= 1'b0;
			// External active edge starts the pulse
			else if (pulseMode & extEdge & ~runBit)
				ctrl0_q[`PT_CTRL0_RUN] <= 1'b1;
		end
	end

	// Configuration registers
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl1_q  <= ctrl1_t'(`PT_RESET_BYTE);
			cmpA_q   <= 10'h0;
			period_q <= 10'h0;
		end
		else if (busWrite)
		begin
			case (wbReq.adr)
				`PT_OFF_CTRL1:  ctrl1_q <= ctrl1_t'({wbReq.dat[7:2], 1'b0, wbReq.dat[0]});
				`PT_OFF_CMPA_LO: cmpA_q[7:0] <= wbReq.dat[7:0];
				`PT_OFF_CMPA_HI: cmpA_q[9:8] <= wbReq.dat[1:0];
				`PT_OFF_PER_LO:  period_q[7:0] <= wbReq.dat[7:0];
				`PT_OFF_PER_HI:  period_q[9:8] <= wbReq.dat[1:0];
				default:         ;
			endcase
		end
	end

	// Sticky match flags; a write of one clears, a new match wins
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flagA_q <= 1'b0;
			flagP_q <= 1'b0;
		end
		else
		begin
			flagA_q <= raiseA | (flagA_q & ~(busWrite & (wbReq.adr == `PT_OFF_FLAGS)
			           & wbReq.dat[`PT_FLAG_A]));
			flagP_q <= raiseP | (flagP_q & ~(busWrite & (wbReq.adr == `PT_OFF_FLAGS)
			           & wbReq.dat[`PT_FLAG_P]));
		end
	end

	assign matchAPulse = raiseA;
	assign matchPPulse = raiseP;

	// Active while count below duty; duty at or above period stays active
	assign pwmActive = (count_q < cmpA_q) |
	                   ((period_q != 10'h0) & (cmpA_q >= period_q));

	// Pin level state for compare and single-pulse modes
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			pin_q <= 1'b0;
		// Run rise loads initial level; pulse starts here
		else if (runRise)
			pin_q <= ctrl1_q.initLevel;
		// Trailing edge: back to the inactive level once run drops
		else if (pulseMode & ~runBit)
			pin_q <= ~ctrl1_q.initLevel;
		// Only match A moves the pin in compare mode
		else if ((ctrl1_q.mode == MODE_COMPARE) & raiseA)
		begin
			case (ctrl1_q.pinAction)
				2'h1:    pin_q <= 1'b0;
				2'h2:    pin_q <= 1'b1;
				2'h3:    pin_q <= ~pin_q;
				default: pin_q <= pin_q;
			endcase
		end
	end

	// PWM pin: pass or force, polarity from initial level, then invert
	always_comb
	begin
		logic lvl;
		lvl = 1'b0;
		if (pwmMode)
		begin
			case (ctrl1_q.pinAction)
				2'h0:    lvl = ~ctrl1_q.initLevel;
				2'h1:    lvl = ctrl1_q.initLevel;
				default: lvl = pwmActive ? ctrl1_q.initLevel : ~ctrl1_q.initLevel;
			endcase
		end
		else
			lvl = pin_q;
		timerOut = lvl ^ ctrl1_q.invert;
	end

	// Pin released in timer mode; enable low while driving
	assign timerOutEn_n = (ctrl1_q.mode == MODE_TIMER) | (ctrl1_q.mode == MODE_UNDEF);

	// Wishbone slave: one wait state, ack for one cycle, unmapped reads zero
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			ack_q <= wbReq.cyc & wbReq.stb & ~ack_q;
			if (busRead)
			begin
				case (wbReq.adr)
					`PT_OFF_CTRL0:   rdat_q <= {24'h0, ctrl0_q};
					`PT_OFF_CTRL1:   rdat_q <= {24'h0, ctrl1_q};
					`PT_OFF_CNT_LO:  rdat_q <= {24'h0, count_q[7:0]};
					`PT_OFF_CNT_HI:  rdat_q <= {30'h0, count_q[9:8]};
					`PT_OFF_CMPA_LO: rdat_q <= {24'h0, cmpA_q[7:0]};
					`PT_OFF_CMPA_HI: rdat_q <= {30'h0, cmpA_q[9:8]};
					`PT_OFF_PER_LO:  rdat_q <= {24'h0, period_q[7:0]};
					`PT_OFF_PER_HI:  rdat_q <= {30'h0, period_q[9:8]};
					`PT_OFF_FLAGS:   rdat_q <= {30'h0, flagP_q, flagA_q};
					default:         rdat_q <= 32'h0;
				endcase
			end
		end
	end

	assign wbRsp = '{ack: ack_q, dat: rdat_q};

endmodule

// *** inc/periodic_timer_defines.svh ***
/*
 Register offsets, field positions, reset values and counts of the periodic timer.
 Assumes a 32-bit classic Wishbone slave, one register per aligned word.
*/
`ifndef PERIODIC_TIMER_DEFINES_SVH
`define PERIODIC_TIMER_DEFINES_SVH

`define PT_ADDR_W       6
`define PT_OFF_CTRL0    6'h00
`define PT_OFF_CTRL1    6'h04
`define PT_OFF_CNT_LO   6'h08
`define PT_OFF_CNT_HI   6'h0c
`define PT_OFF_CMPA_LO  6'h10
`define PT_OFF_CMPA_HI  6'h14
`define PT_OFF_PER_LO   6'h18
`define PT_OFF_PER_HI   6'h1c
`define PT_OFF_FLAGS    6'h20

`define PT_CTRL0_PAUSE  7
`define PT_CTRL0_CKHI   6
`define PT_CTRL0_CKLO   4
`define PT_CTRL0_RUN    3
`define PT_CTRL1_MHI    7
`define PT_CTRL1_MLO    6
`define PT_CTRL1_IOHI   5
`define PT_CTRL1_IOLO   4
`define PT_CTRL1_INIT   3
`define PT_CTRL1_INV    2
`define PT_CTRL1_CCLR   0
`define PT_FLAG_A       0
`define PT_FLAG_P       1

`define PT_CNT_W        10
`define PT_CNT_MAX      10'h3ff
`define PT_RESET_BYTE   8'h00
`define PT_DIV4         2'h3
`define PT_DIV16        4'hf
`define PT_DIV64        6'h3f

`endif

// *** inc/periodic_timer_pkg.sv ***
/*
 Types of the periodic timer: mode and clock select encodings, the control word.
 Assumes the defines header is included by users of offsets.
*/
package periodic_timer_pkg;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_UNDEF   = 2'h1,
		MODE_PWM     = 2'h2,
		MODE_TIMER   = 2'h3
	} mode_t;

	typedef enum logic [2:0] {
		CLK_SYS_DIV4 = 3'h0,
		CLK_SYS      = 3'h1,
		CLK_H_DIV16  = 3'h2,
		CLK_H_DIV64  = 3'h3,
		CLK_SUB_A    = 3'h4,
		CLK_SUB_B    = 3'h5,
		CLK_PIN_RISE = 3'h6,
		CLK_PIN_FALL = 3'h7
	} clk_sel_t;

	// Control fields that steer the counter and the pin
	typedef struct packed {
		mode_t      mode;
		logic [1:0] pinAction;
		logic       initLevel;
		logic       invert;
		logic       reserved;
		logic       clearSel;
	} ctrl1_t;

	// Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [5:0]  adr;
		logic [31:0] dat;
	} wb_req_t;

	// Wishbone answer from the slave
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

endpackage

// *** tb/periodic_timer_properties.sv ***
/*
 Checker of the periodic timer, bound to its top module.
 Assumes one clock and a master that holds each request until ack.
*/
`timescale 1ns/100ps
`include "periodic_timer_defines.svh"
module periodic_timer_properties
	import periodic_timer_pkg::*;
(
	// Clock and reset
	input wire logic                        clock,
	input wire logic                        sys_rst,
	// Register bus
	input wire periodic_timer_pkg::wb_req_t wbReq,
	input wire periodic_timer_pkg::wb_rsp_t wbRsp,
	// Pin and events
	input wire logic                        timerOut,
	input wire logic                        timerOutEn_n,
	input wire logic                        matchAPulse,
	input wire logic                        matchPPulse
);
	logic       take;
	logic       wrTake;
	logic       runQ;
	logic [7:0] ctlQ;

	// Taken request; writes land on this same edge
	assign take = wbReq.cyc && wbReq.stb && !wbRsp.ack;
	assign wrTake = take && wbReq.we && wbReq.sel[0];

	// Shadow of the run bit, software view only
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			runQ <= 1'b0;
		else if (wrTake && wbReq.adr == `PT_OFF_CTRL0)
			runQ <= wbReq.dat[3];

	// Shadow of the mode and pin control word
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			ctlQ <= 8'h00;
		else if (wrTake && wbReq.adr == `PT_OFF_CTRL1)
			ctlQ <= wbReq.dat[7:0];

	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	AST_ACK_NEXT: assert property (take |=> wbRsp.ack)
		else $error("ack missing after a taken request");
	AST_ACK_SHORT: assert property (wbRsp.ack |=> !wbRsp.ack)
		else $error("ack held for more than one cycle");
	AST_UNMAPPED: assert property (take && !wbReq.we && (wbReq.adr > 6'h20
		|| wbReq.adr[1:0] != 2'h0) |=> wbRsp.dat == 32'h0)
		else $error("unmapped read not zero");
	AST_PIN_EN: assert property (timerOutEn_n == ctlQ[6])
		else $error("pin enable does not follow the mode");
	AST_PIN_ON_A: assert property (ctlQ[7:6] == 2'h0 && !$past(wrTake) && !$past(wrTake, 2)
		&& $changed(timerOut) |-> matchAPulse || $past(matchAPulse))
		else $error("compare pin moved without a match A");
	AST_RUN_INIT: assert property (wrTake && wbReq.adr == `PT_OFF_CTRL0
		&& wbReq.dat[3] && !runQ && ctlQ[7:6] == 2'h0 && !ctlQ[2]
		|-> ##2 timerOut == ctlQ[3])
		else $error("run start did not load the initial level");
	AST_NO_P: assert property (ctlQ[0] && ctlQ[6] == ctlQ[7] |-> !matchPPulse)
		else $error("match P raised with clear on A");
	AST_SP_END: assert property (ctlQ[7:4] == 4'hb && !ctlQ[2]
		&& matchAPulse |-> ##[1:2] timerOut != ctlQ[3])
		else $error("single pulse not ended by match A");

	COV_READ: cover property (take && !wbReq.we);
	COV_MATCH_P: cover property (matchPPulse);
	COV_PULSE_END: cover property (ctlQ[7:4] == 4'hb && matchAPulse);
endmodule

bind periodic_timer periodic_timer_properties u_periodic_timer_properties (
	.clock, .sys_rst, .wbReq, .wbRsp, .timerOut, .timerOutEn_n,
	.matchAPulse, .matchPPulse
);

// *** tb/periodic_timer_tb_top.sv ***
/*
 Testbench of the periodic timer: bus tasks, a byte model of the registers,
 pin and event counting. Assumes the checker binds itself to the design.
*/
`timescale 1ns/100ps
`include "periodic_timer_defines.svh"
module periodic_timer_tb_top;
	import periodic_timer_pkg::*;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	wb_req_t     req = '0;
	wb_rsp_t     rsp;
	logic        ext = 1'b0;
	logic        fast = 1'b0;
	logic        sub = 1'b0;
	logic        pin;
	logic        pinEn_n;
	logic        pA;
	logic        pP;
	logic [7:0]  mdl [64] = '{default: 8'h00};
	logic [5:0]  rw [6] = '{6'h04, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h3c};
	logic [7:0]  pc [5] = '{8'h00, 8'h18, 8'h20, 8'h30, 8'hc0};
	int          pe [5] = '{0, 1, 1, 10, 0};
	logic [7:0]  pw [5] = '{8'ha8, 8'hac, 8'h88, 8'h98, 8'ha8};
	logic [9:0]  pd [5] = '{10'h003, 10'h003, 10'h003, 10'h003, 10'h00c};
	int          ph [5] = '{30, 70, 0, 100, 100};
	logic [2:0]  cs [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	int          mul [4] = '{4, 1, 96, 16};
	logic [31:0] rnd;
	int          seed = 32'h831b79ed;
	int          cyc = 0;
	int          n_errors = 0;
	int          tests_run = 0;
	int          nA;
	int          nP;
	int          nHi;
	int          nEdge;
	int          gapA;
	int          gapP;

	periodic_timer u_periodic_timer (
		.clock, .sys_rst, .wbReq(req), .wbRsp(rsp), .extCountPin(ext),
		.fastClkTick(fast), .subClkTick(sub), .timerOut(pin),
		.timerOutEn_n(pinEn_n), .matchAPulse(pA), .matchPPulse(pP)
	);

	// 250 MHz clock
	always #2 clock = ~clock;

	// Slow sources: fast wave of 6 clocks, sub wave of 16 clocks
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		fast <= (cyc % 6) < 3;
		sub <= (cyc % 16) < 8;
	end

	// Hang guard, far beyond the planned 7500 cycles
	initial
	begin
		#200000;
		n_errors++;
		test_done();
	end

	task automatic test_done;
		$display("errors %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chkReg(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %0t: read %h, model %h", $time, g, e);
		end
	endtask

	task automatic chkCnt(input int g, input int lo, input int hi);
		tests_run++;
		if (g < lo || g > hi)
		begin
			n_errors++;
			$display("Error %0t: count %0d, expected %0d..%0d", $time, g, lo, hi);
		end
	endtask

	// One classic cycle; waits for ack, a dead slave is caught by the hang guard
	task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clock);
		req <= '{1'b1, 1'b1, w, 4'h1, a, {24'h0, d}};
		do
		begin
			@(posedge clock);
		end
		while (rsp.ack !== 1'b1);
		q = rsp.dat;
		req <= '0;
	endtask

	// Model keeps only the bits that exist
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] q;
		case (a)
			6'h00: mdl[a] = d & 8'hf8;
			6'h04: mdl[a] = d & 8'hfd;
			6'h10, 6'h18: mdl[a] = d;
			6'h14, 6'h1c: mdl[a] = d & 8'h03;
			default: mdl[a] = 8'h00;
		endcase
		bus(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [5:0] a);
		logic [31:0] q;
		bus(a, 1'b0, 8'h00, q);
		chkReg(q, {24'h0, mdl[a]});
	endtask

	// stops first, since mode changes while running are undefined
	task automatic go(input logic [7:0] c1, input logic [9:0] ca, input logic [9:0] cp,
		input logic [7:0] c0);
		wr(`PT_OFF_CTRL0, 8'h00);
		wr(`PT_OFF_CTRL1, c1);
		wr(`PT_OFF_CMPA_LO, ca[7:0]);
		wr(`PT_OFF_CMPA_HI, {6'h00, ca[9:8]});
		wr(`PT_OFF_PER_LO, cp[7:0]);
		wr(`PT_OFF_PER_HI, {6'h00, cp[9:8]});
		wr(`PT_OFF_CTRL0, c0);
	endtask

	// Counts events, pin high cycles, pin edges and last pulse gaps
	task automatic meas(input int n);
		int   lastA;
		int   lastP;
		logic prev;
		nA = 0;
		nP = 0;
		nHi = 0;
		nEdge = 0;
		lastA = 0;
		lastP = 0;
		// One edge first, so a run start has reached the pin before history begins
		@(posedge clock);
		prev = pin;
		repeat (n)
		begin
			@(posedge clock);
			if (pA === 1'b1)
			begin
				nA++;
				gapA = cyc - lastA;
				lastA = cyc;
			end
			if (pP === 1'b1)
			begin
				nP++;
				gapP = cyc - lastP;
				lastP = cyc;
			end
			nHi += (pin === 1'b1);
			nEdge += (pin !== prev);
			prev = pin;
		end
	endtask

	// Main sequence
	initial
	begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		for (int a = 0; a < 64; a += 4)
			rd(6'(a));
		foreach (rw[i])
		begin
			rnd = $random(seed);
			wr(rw[i], rnd[7:0]);
			rd(rw[i]);
		end
		// compare A stays nonzero in compare mode
		foreach (pc[i])
		begin
			go(pc[i], 10'h003, 10'h008, 8'h18);
			meas(80);
			chkCnt(nA, 10, 10);
			chkReg({31'h0, pinEn_n}, {31'h0, pc[i][6]});
			chkCnt(nP, 10, 10);
			chkCnt(gapP, 8, 8);
			chkCnt(nEdge, pe[i], pe[i]);
		end
		go(8'h31, 10'h005, 10'h002, 8'h18);
		meas(60);
		chkCnt(gapA, 5, 5);
		chkCnt(nP, 0, 0);
		wr(`PT_OFF_CTRL0, 8'h98);
		meas(40);
		chkCnt(nA, 0, 0);
		mdl[`PT_OFF_FLAGS] = 8'h03;
		rd(`PT_OFF_FLAGS);
		wr(`PT_OFF_FLAGS, 8'h03);
		rd(`PT_OFF_FLAGS);
		foreach (cs[i])
		begin
			go(8'h30, 10'h003, 10'h005, {1'b0, cs[i], 4'h8});
			meas(15 * mul[i] + 8);
			chkCnt(gapP, 5 * mul[i], 5 * mul[i]);
		end
		go(8'hc0, 10'h000, 10'h000, 8'h18);
		meas(2100);
		chkCnt(nA, 0, 0);
		foreach (pw[i])
		begin
			go(pw[i], pd[i], 10'h00a, 8'h18);
			meas(100);
			chkCnt(nHi, ph[i], ph[i]);
			chkCnt(nP, 10, 10);
			chkCnt(gapP, 10, 10);
		end
		go(8'ha8, 10'h200, 10'h000, 8'h18);
		meas(2048);
		chkCnt(nHi, 1024, 1024);
		// pin action held at single pulse
		go(8'hb8, 10'h006, 10'h000, 8'h10);
		fork
			wr(`PT_OFF_CTRL0, 8'h18);
			meas(40);
		join
		chkCnt(nHi, 6, 7);
		chkCnt(nEdge, 2, 2);
		chkCnt(nA, 1, 1);
		mdl[0] = 8'h10;
		rd(`PT_OFF_CTRL0);
		fork
			ext <= 1'b1;
			meas(40);
		join
		chkCnt(nEdge, 2, 2);
		test_done();
	end
endmodule
